// file: cdt_pkg.sv
// ****************************************************************
// shared constants for the transceiver channel controller
// ****************************************************************
package cdt_pkg;

    // clock and bit timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int BIT_TIME_NS    = 2000;  // 500 kbit/s nominal
    localparam int BIT_CYCLES     = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_CYCLE   = BIT_CYCLES / 4;  // down-count value, 75 % into the bit

    // dominant-hold supervision in the transceiver
    localparam int DOM_LIMIT_NS   = 1200000;  // 1.2 ms least timeout
    localparam int MAX_DOM_BITS   = 11;
    localparam int DOM_MAX_CYCLES = MAX_DOM_BITS * BIT_CYCLES;

    // mode change settling, a longest time in the device, so we wait it out rounded up
    localparam int MODE_SWITCH_NS = 20000;
    localparam int MODE_CYCLES    = (MODE_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // widths
    localparam int BIT_CNT_W      = 8;
    localparam int DOM_RUN_W      = 4;
    localparam int MODE_CNT_W     = 12;
    localparam int AGE_W          = 13;
    localparam int DOM_AGE_W      = 13;

    // sized constants used in the logic
    localparam logic [BIT_CNT_W-1:0]  BIT_LAST     = BIT_CNT_W'(BIT_CYCLES - 1);
    localparam logic [BIT_CNT_W-1:0]  BIT_SAMPLE   = BIT_CNT_W'(SAMPLE_CYCLE);
    localparam logic [BIT_CNT_W-1:0]  BIT_ZERO     = 8'h00;
    localparam logic [DOM_RUN_W-1:0]  DOM_RUN_MAX  = DOM_RUN_W'(MAX_DOM_BITS);
    localparam logic [DOM_RUN_W-1:0]  DOM_RUN_ZERO = 4'h0;
    localparam logic [MODE_CNT_W-1:0] MODE_LAST    = MODE_CNT_W'(MODE_CYCLES - 1);
    localparam logic [MODE_CNT_W-1:0] MODE_ZERO    = 12'h000;
    localparam logic [1:0]            FIFO_DEPTH   = 2'h2;
    localparam logic [1:0]            FIFO_EMPTY   = 2'h0;

    // controller states
    typedef enum logic [1:0] {
        ST_NORMAL_WAIT,
        ST_NORMAL,
        ST_STBY_WAIT,
        ST_STANDBY
    } cdt_state_t;

endpackage

// file: cdt_host_ctrl.sv
`timescale 1ns/1ps

// ****************************************************************
// controller for one transceiver channel
// ****************************************************************

module cdt_host_ctrl (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic txBit,
    input  wire logic txValid,
    output logic      txReady,
    input  wire logic standbyReq,
    output logic      modeReady,
    output logic      wakeSeen,
    output logic      limitHit,
    output logic      rxBit,
    output logic      rxValid,
    output logic      transmit_bit_in,
    output logic      low_power_select,
    input  wire logic receive_bit_out
);

    // ****************************************************************
    // state
    // ****************************************************************

    typedef struct packed {
        cdt_pkg::cdt_state_t                st;
        logic                               lps;
        logic                               txd;
        logic [cdt_pkg::BIT_CNT_W-1:0]      bitCnt;
        logic [cdt_pkg::DOM_RUN_W-1:0]      domRun;
        logic [cdt_pkg::MODE_CNT_W-1:0]     modeCnt;
        logic                               modeRdy;
        logic [1:0]                         mem;
        logic                               wrPtr;
        logic                               rdPtr;
        logic [1:0]                         cnt;
        logic                               ready;
        logic                               rxPrev;
        logic                               rxBit;
        logic                               rxValid;
        logic                               wake;
        logic                               limit;
    } cdt_regs_t;

    cdt_regs_t s_q;
    cdt_regs_t s_d;

    // true once the dominant run has reached the allowed number of bits
    function automatic logic domLimit(input logic [cdt_pkg::DOM_RUN_W-1:0] run);
        domLimit = (run >= cdt_pkg::DOM_RUN_MAX);
    endfunction

    // ****************************************************************
    // next-state logic
    // ****************************************************************

    always_comb begin
        logic push;
        logic pop;
        logic head;
        push = 1'b0;
        pop  = 1'b0;
        head = 1'b1;
        s_d  = s_q;
        s_d.rxValid = 1'b0;
        s_d.wake    = 1'b0;
        s_d.limit   = 1'b0;
        s_d.rxPrev  = receive_bit_out;
        push = txValid && s_q.ready;
        head = s_q.mem[s_q.rdPtr];

        case (s_q.st)
            // select driven low, wait for the channel to settle in normal
            cdt_pkg::ST_NORMAL_WAIT: begin
                s_d.modeCnt = s_q.modeCnt + 12'h001;
                if (s_q.modeCnt == cdt_pkg::MODE_LAST) begin
                    s_d.st      = cdt_pkg::ST_NORMAL;
                    s_d.modeRdy = 1'b1;
                    s_d.bitCnt  = cdt_pkg::BIT_ZERO;
                    s_d.domRun  = cdt_pkg::DOM_RUN_ZERO;
                end
            end
            // bit serialiser and receive sampler
            cdt_pkg::ST_NORMAL: begin
                if (standbyReq) begin
                    s_d.st      = cdt_pkg::ST_STBY_WAIT;
                    s_d.lps     = 1'b1;
                    s_d.txd     = 1'b1;
                    s_d.modeRdy = 1'b0;
                    s_d.modeCnt = cdt_pkg::MODE_ZERO;
                    s_d.domRun  = cdt_pkg::DOM_RUN_ZERO;
                end else if (s_q.bitCnt == cdt_pkg::BIT_ZERO) begin
                    s_d.bitCnt = cdt_pkg::BIT_LAST;
                    if (s_q.cnt != cdt_pkg::FIFO_EMPTY) begin
                        if (!head && domLimit(s_q.domRun)) begin
                            // force one recessive bit, keep the dominant bit queued
                            s_d.txd    = 1'b1;
                            s_d.domRun = cdt_pkg::DOM_RUN_ZERO;
                            s_d.limit  = 1'b1;
                        end else begin
                            s_d.txd    = head;
                            pop        = 1'b1;
                            s_d.domRun = head ? cdt_pkg::DOM_RUN_ZERO : s_q.domRun + 4'h1;
                        end
                    end else begin
                        s_d.txd    = 1'b1;  // idle is recessive
                        s_d.domRun = cdt_pkg::DOM_RUN_ZERO;
                    end
                end else begin
                    s_d.bitCnt = s_q.bitCnt - 8'h01;
                    if (s_q.bitCnt == cdt_pkg::BIT_SAMPLE) begin
                        s_d.rxBit   = receive_bit_out;  // low reads as dominant
                        s_d.rxValid = 1'b1;
                    end
                end
            end
            // select driven high, wait for standby to settle
            cdt_pkg::ST_STBY_WAIT: begin
                s_d.modeCnt = s_q.modeCnt + 12'h001;
                if (s_q.modeCnt == cdt_pkg::MODE_LAST) begin
                    s_d.st = cdt_pkg::ST_STANDBY;
                end
            end
            // watch for wake request or a user return to normal
            cdt_pkg::ST_STANDBY: begin
                if (!standbyReq || (s_q.rxPrev && !receive_bit_out)) begin
                    s_d.st      = cdt_pkg::ST_NORMAL_WAIT;
                    s_d.lps     = 1'b0;
                    s_d.modeCnt = cdt_pkg::MODE_ZERO;
                    s_d.wake    = s_q.rxPrev && !receive_bit_out;
                end
            end
            default: begin
                s_d.st  = cdt_pkg::ST_NORMAL_WAIT;
                s_d.lps = 1'b0;
                s_d.txd = 1'b1;
            end
        endcase

        // two-entry transmit buffer
        if (push) begin
            s_d.mem[s_q.wrPtr] = txBit;
            s_d.wrPtr          = ~s_q.wrPtr;
        end
        if (pop) begin
            s_d.rdPtr = ~s_q.rdPtr;
        end
        s_d.cnt   = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
        s_d.ready = (s_d.cnt < cdt_pkg::FIFO_DEPTH);
    end

    // ****************************************************************
    // state register
    // ****************************************************************

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_q         <= '0;
            s_q.st      <= cdt_pkg::ST_NORMAL_WAIT;
            s_q.lps     <= 1'b0;  // start towards normal
            s_q.txd     <= 1'b1;
            s_q.ready   <= 1'b1;
            s_q.rxPrev  <= 1'b1;
            s_q.rxBit   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    assign txReady          = s_q.ready;
    assign modeReady        = s_q.modeRdy;
    assign wakeSeen         = s_q.wake;
    assign limitHit         = s_q.limit;
    assign rxBit            = s_q.rxBit;
    assign rxValid          = s_q.rxValid;
    assign transmit_bit_in  = s_q.txd;
    assign low_power_select = s_q.lps;

    // ****************************************************************
    // checks
    // ****************************************************************

    // helper ages: cycles since select changed, cycles of continuous dominant
    logic [cdt_pkg::AGE_W-1:0]     modeAge;
    logic [cdt_pkg::DOM_AGE_W-1:0] domAge;
    logic                          lpsPrev;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            modeAge <= '0;
            domAge  <= '0;
            lpsPrev <= 1'b0;
        end else begin
            lpsPrev <= low_power_select;
            if (low_power_select != lpsPrev) begin
                modeAge <= 13'h0001;  // change is seen one cycle late, count that cycle
            end else if (modeAge != '1) begin
                modeAge <= modeAge + 13'h0001;
            end
            if (transmit_bit_in) begin
                domAge <= '0;
            end else if (domAge != '1) begin
                domAge <= domAge + 13'h0001;
            end
        end
    end

    property p_dom_only_normal;
        @(posedge core_clk) disable iff (sys_rst)
        !transmit_bit_in |-> (s_q.st == cdt_pkg::ST_NORMAL);
    endproperty
    a_dom_only_normal: assert property (p_dom_only_normal)
        else $error("dominant driven outside normal mode");

    property p_rec_outside_normal;
        @(posedge core_clk) disable iff (sys_rst)
        (s_q.st != cdt_pkg::ST_NORMAL) |-> transmit_bit_in;
    endproperty
    a_rec_outside_normal: assert property (p_rec_outside_normal)
        else $error("transmit not recessive outside normal mode");

    property p_rx_sample;
        @(posedge core_clk) disable iff (sys_rst)
        rxValid |-> (rxBit == $past(receive_bit_out));
    endproperty
    a_rx_sample: assert property (p_rx_sample)
        else $error("received bit does not match bus level");

    property p_dom_run_bound;
        @(posedge core_clk) disable iff (sys_rst)
        domAge <= 13'(cdt_pkg::DOM_MAX_CYCLES);
    endproperty
    a_dom_run_bound: assert property (p_dom_run_bound)
        else $error("dominant held longer than eleven bit times");

    property p_limit_recessive;
        @(posedge core_clk) disable iff (sys_rst)
        limitHit |-> transmit_bit_in ##1 transmit_bit_in;
    endproperty
    a_limit_recessive: assert property (p_limit_recessive)
        else $error("forced recessive bit not on the pin");

    property p_reset_normal;
        @(posedge core_clk)
        $past(sys_rst) |-> !low_power_select;
    endproperty
    a_reset_normal: assert property (p_reset_normal)
        else $error("select not low after reset");

    property p_select_mode;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(low_power_select) |-> !modeReady && transmit_bit_in;
    endproperty
    a_select_mode: assert property (p_select_mode)
        else $error("standby entered while normal traffic active");

    property p_mode_settle;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(modeReady) |-> (modeAge >= 13'(cdt_pkg::MODE_CYCLES)) && !low_power_select;
    endproperty
    a_mode_settle: assert property (p_mode_settle)
        else $error("normal mode declared before settle time");

    c_limit: cover property (@(posedge core_clk) disable iff (sys_rst) limitHit);
    c_wake:  cover property (@(posedge core_clk) disable iff (sys_rst) wakeSeen);
    c_full:  cover property (@(posedge core_clk) disable iff (sys_rst) txValid && !txReady);
    c_rx:    cover property (@(posedge core_clk) disable iff (sys_rst) rxValid && !rxBit);

endmodule

// file: cdt_xcvr_model.sv
`timescale 1ns/1ps

// ****************************************************************
// behavioural model of one transceiver channel
// ****************************************************************
module cdt_xcvr_model #(
    parameter int DOM_LIMIT  = 150000,
    parameter int MODE_DELAY = 100,
    parameter int WAKE_FILT  = 63
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic transmit_bit_in,
    input  wire logic low_power_select,
    input  wire logic otherDom,
    output logic      receive_bit_out
);
    logic stby_q;
    logic txPrev_q;
    logic fault_q;
    logic woken_q;
    logic selHigh;
    logic driverOn;
    logic busDom;
    int   modeCnt_q;
    int   domCnt_q;
    int   wakeCnt_q;

    // an undriven select pin reads as standby through the pull-up
    assign selHigh = (low_power_select !== 1'h0);
    // the driver is live only in normal mode and without a hold fault
    assign driverOn = !stby_q && !fault_q;
    // any dominant driver wins over recessive ones on the shared bus
    assign busDom = (driverOn && !transmit_bit_in) || otherDom;
    // receive pin mirrors the bus, but stays high in standby until a wake
    assign receive_bit_out = (stby_q && !woken_q) ? 1'h1 : !busDom;

    // mode settling, wake filter and dominant-hold supervision
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stby_q    <= 1'h1;
            txPrev_q  <= 1'h1;
            fault_q   <= 1'h0;
            woken_q   <= 1'h0;
            modeCnt_q <= 0;
            domCnt_q  <= 0;
            wakeCnt_q <= 0;
        end else begin
            txPrev_q <= transmit_bit_in;
            if (selHigh != stby_q) begin
                modeCnt_q <= modeCnt_q + 1;
                if (modeCnt_q >= MODE_DELAY) begin
                    stby_q    <= selHigh;
                    modeCnt_q <= 0;
                end
            end else begin
                modeCnt_q <= 0;
            end
            if (stby_q && otherDom) begin
                wakeCnt_q <= wakeCnt_q + 1;
                if (wakeCnt_q >= WAKE_FILT) begin
                    woken_q <= 1'h1;
                end
            end else if (stby_q) begin
                wakeCnt_q <= 0;
            end else begin
                wakeCnt_q <= 0;
                woken_q   <= 1'h0;
            end
            if (stby_q || transmit_bit_in) begin
                domCnt_q <= 0;
                fault_q  <= 1'h0;
            end else if (txPrev_q) begin
                domCnt_q <= 1;
            end else if (domCnt_q >= DOM_LIMIT) begin
                fault_q <= 1'h1;
            end else begin
                domCnt_q <= domCnt_q + 1;
            end
        end
    end
endmodule

// file: testbench.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

// ****************************************************************
// self-checking bench for the channel controller
// ****************************************************************
module testbench;
    logic core_clk, sys_rst, txBit, txValid, txReady, standbyReq, modeReady;
    logic wakeSeen, limitHit, rxBit, rxValid, transmit_bit_in, low_power_select;
    logic receive_bit_out, otherDom, randBus, hitSeen, expHit, expBit;
    logic expQ[$];
    int   errors = 0, checked = 0, seed = 73184, cycles = 0;
    int   domRun = 0, rxCount = 0, i, n, rxMark;

    cdt_host_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .txBit(txBit),
        .txValid(txValid), .txReady(txReady), .standbyReq(standbyReq),
        .modeReady(modeReady), .wakeSeen(wakeSeen), .limitHit(limitHit), .rxBit(rxBit),
        .rxValid(rxValid), .transmit_bit_in(transmit_bit_in),
        .low_power_select(low_power_select), .receive_bit_out(receive_bit_out));

    cdt_xcvr_model u_xcvr (.core_clk(core_clk), .sys_rst(sys_rst),
        .transmit_bit_in(transmit_bit_in), .low_power_select(low_power_select),
        .otherDom(otherDom), .receive_bit_out(receive_bit_out));

    // clock and hang guard
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 50000) begin
            errors++;
            stop_test();
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic stop_test;
        begin
            $display("checked=%0d errors=%0d", checked, errors);
            if (errors == 0 && checked > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask

    // offer one bit from a falling edge, hold it until taken
    task automatic send_bit(input logic b);
        logic rdy;
        begin
            txBit = b;
            txValid = 1'h1;
            rdy = 1'h0;
            while (!rdy) begin
                rdy = txReady;
                @(posedge core_clk);
                if (!rdy) @(negedge core_clk);
            end
            expQ.push_back(b);
            @(negedge core_clk);
        end
    endtask

    // wait until every queued bit has gone out, then 300 more cycles, a little over one bit time
    task automatic drain;
        begin
            n = 0;
            while (expQ.size() != 0 && n < 20000) begin
                @(negedge core_clk);
                n++;
            end
            repeat (300) @(negedge core_clk);
        end
    endtask

    // reference model: bit order, dominant limit and sampled bus level
    always @(negedge core_clk) begin
        if (limitHit === 1'h1) hitSeen = 1'h1;
        if (rxValid === 1'h1) begin
            expHit = 1'h0;
            if (expQ.size() != 0 && expQ[0] == 1'h0 && domRun == cdt_pkg::MAX_DOM_BITS) begin
                expBit = 1'h1;
                expHit = 1'h1;
            end else if (expQ.size() != 0) expBit = expQ.pop_front();
            else expBit = 1'h1;
            domRun = expBit ? 0 : domRun + 1;
            `CHK(transmit_bit_in, expBit)
            `CHK(rxBit, expBit & ~otherDom)
            `CHK(hitSeen, expHit)
            hitSeen = 1'h0;
            rxCount++;
            otherDom = randBus ? ($random(seed) % 4 == 0) : 1'h0;
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        core_clk = 1'h0; sys_rst = 1'h1; txBit = 1'h1; txValid = 1'h0;
        standbyReq = 1'h0; otherDom = 1'h0; randBus = 1'h0; hitSeen = 1'h0;
        repeat (10) @(negedge core_clk);
        sys_rst = 1'h0;
        @(negedge core_clk);
        `CHK(transmit_bit_in, 1'h1)
        `CHK(rxBit, 1'h1)
        `CHK(low_power_select, 1'h0)
        `CHK(modeReady, 1'h0)
        randBus = 1'h1;
        // buffer fills while settling, then a long dominant run and random bits
        send_bit(1'h0);
        send_bit(1'h0);
        `CHK(txReady, 1'h0)
        for (i = 0; i < 12; i++) send_bit(1'h0);
        for (i = 0; i < 20; i++) send_bit(1'($random(seed)));
        txValid = 1'h0;
        randBus = 1'h0;
        drain();
        // standby entry: select high, driver forced recessive, no sampling
        standbyReq = 1'h1;
        repeat (2) @(negedge core_clk);
        `CHK(low_power_select, 1'h1)
        `CHK(modeReady, 1'h0)
        `CHK(transmit_bit_in, 1'h1)
        rxMark = rxCount;
        send_bit(1'h0);
        send_bit(1'h1);
        `CHK(txReady, 1'h0)
        txValid = 1'h0;
        repeat (2600) @(negedge core_clk);
        `CHK(rxCount, rxMark)
        // remote activity wakes the channel back to normal
        otherDom = 1'h1;
        n = 0;
        while (wakeSeen !== 1'h1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(wakeSeen, 1'h1)
        `CHK(low_power_select, 1'h0)
        standbyReq = 1'h0;
        otherDom = 1'h0;
        n = 0;
        while (modeReady !== 1'h1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n, cdt_pkg::MODE_CYCLES)
        randBus = 1'h1;
        for (i = 0; i < 14; i++) send_bit(1'($random(seed)));
        txValid = 1'h0;
        drain();
        // user return: settle in standby, then drop the request with a quiet bus
        standbyReq = 1'h1;
        repeat (2600) @(negedge core_clk);
        `CHK(low_power_select, 1'h1)
        standbyReq = 1'h0;
        @(negedge core_clk);
        `CHK(low_power_select, 1'h0)
        `CHK(wakeSeen, 1'h0)
        n = 0;
        while (modeReady !== 1'h1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n, cdt_pkg::MODE_CYCLES)
        stop_test();
    end
endmodule
